// ### src/ccm_unit.v
// carrier clear and manage command sequencer
// Notes on behaviour
// R1: clear writes the fill byte from first address, ignoring write protection.
// R2: clear byte count zero means up to the carrier's last address.
// R3: whole-carrier clear skips the two production month/year bytes.
// R4: finishing sets done; comm error tells normal from error end.
// R5: host issues commands only while ready is high.
// R6: each write count record is a 3-byte counter anywhere in memory.
// R7: manage mode selects increment or decrement counting.
// R8: each manage call changes the counter by the given step.
// R9: count-up adds step; warning when count exceeds 100,000.
// R10: count-down subtracts step; warning when count reaches zero.
// R11: generate mode stores check code in area's last two bytes.
// R12: check code is CRC-16, polynomial x^16+x^12+x^5+1.
// R13: verify recomputes over area and code; warning on mismatch.
// R14: verify length covers data bytes plus two code bytes.
// R15: host never writes its own data into the code bytes.
// R16: with interrupt refresh, read end starts handler 004, write 005.
// R17: no carrier at command time ends with carrier-missing error.
// R18: CRC preset all ones, msb first, high byte stored first.
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.vh"
module ccm_unit (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // commands
    input wire carrier_clear_cmd,
    input wire carrier_manage_cmd,
    input wire [15:0] first_addr,
    input wire [15:0] byte_count,
    input wire [7:0] fill_byte,
    input wire [1:0] manage_mode,
    input wire [15:0] step_count,
    // carrier configuration
    input wire [15:0] last_addr,
    input wire [15:0] prod_addr,
    input wire carrier_present,
    // status
    output reg ready_q,
    output reg done_q,
    output reg comm_err_q,
    output reg missing_err_q,
    output reg check_warn_q,
    // head memory port
    output reg mem_req_q,
    output reg mem_we_q,
    output reg [15:0] mem_addr_q,
    output reg [7:0] mem_wdata_q,
    input wire mem_ack,
    input wire mem_err,
    input wire [7:0] mem_rdata,
    // completion handlers
    input wire refresh_irq_sel,
    input wire carrier_read_done,
    input wire carrier_write_done,
    output reg handler_start_q,
    output reg [7:0] handler_entry_q
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg pres_m_q;
    reg pres_s_q;
    reg [2:0] st_q;
    reg [2:0] op_q;
    reg [15:0] addr_q;
    reg [15:0] base_q;
    reg [16:0] rd_n_q;
    reg [16:0] wr_n_q;
    reg [23:0] cnt_q;
    reg [15:0] crc_q;
    reg [15:0] step_q;
    reg [15:0] skip_q;
    reg whole_q;
    reg [1:0] idx_q;
    wire [15:0] crc_d;
    wire take;
    wire [16:0] len;
    wire [16:0] whole_len;
    wire [24:0] sum;
    wire skip;
    reg [7:0] wbyte;

    ccm_crc_byte u_crc (
        .crc_in(crc_q),
        .data_in(mem_rdata),
        .crc_out(crc_d)
    );

    assign take = ready_q & (carrier_clear_cmd | carrier_manage_cmd); // R5
    assign len = {1'b0, byte_count};
    assign whole_len = {1'b0, last_addr} - {1'b0, first_addr} + 17'h00001; // R2
    assign sum = {1'b0, cnt_q} + {9'h000, step_q}; // R8 R9
    // production bytes are only protected on a whole-carrier clear
    assign skip = whole_q & ((addr_q == skip_q) | (addr_q == skip_q + 16'h0001)); // R3

    always @* begin
        wbyte = fill_byte;
        case (op_q)
            `CCM_OP_INC, `CCM_OP_DEC: begin
                wbyte = (idx_q == 2'h0) ? cnt_q[23:16] :
                        (idx_q == 2'h1) ? cnt_q[15:8] : cnt_q[7:0]; // R6
            end
            `CCM_OP_GEN: begin
                wbyte = (idx_q == 2'h0) ? crc_q[15:8] : crc_q[7:0]; // R11 R18
            end
            default: begin
                wbyte = fill_byte; // R1
            end
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            pres_m_q <= 1'b0;
            pres_s_q <= 1'b0;
            st_q <= `CCM_ST_IDLE;
            op_q <= `CCM_OP_CLR;
            addr_q <= 16'h0000;
            base_q <= 16'h0000;
            rd_n_q <= 17'h00000;
            wr_n_q <= 17'h00000;
            cnt_q <= 24'h000000;
            crc_q <= `CCM_CRC_PRESET;
            step_q <= 16'h0000;
            skip_q <= 16'h0000;
            whole_q <= 1'b0;
            idx_q <= 2'h0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            comm_err_q <= 1'b0;
            missing_err_q <= 1'b0;
            check_warn_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_wdata_q <= 8'h00;
        end else begin
            pres_m_q <= carrier_present;
            pres_s_q <= pres_m_q;
            case (st_q)
                `CCM_ST_IDLE: begin
                    if (take) begin
                        ready_q <= 1'b0;
                        done_q <= 1'b0;
                        comm_err_q <= 1'b0;
                        missing_err_q <= 1'b0;
                        addr_q <= first_addr;
                        base_q <= first_addr;
                        skip_q <= prod_addr;
                        step_q <= step_count;
                        crc_q <= `CCM_CRC_PRESET; // R18
                        cnt_q <= 24'h000000;
                        idx_q <= 2'h0;
                        whole_q <= 1'b0;
                        if (carrier_manage_cmd) begin
                            check_warn_q <= 1'b0;
                        end
                        if (!pres_s_q) begin
                            comm_err_q <= 1'b1; // R17
                            missing_err_q <= 1'b1; // R17
                            st_q <= `CCM_ST_FIN;
                        end else if (carrier_clear_cmd) begin
                            op_q <= `CCM_OP_CLR;
                            whole_q <= (byte_count == 16'h0000); // R3
                            rd_n_q <= 17'h00000;
                            wr_n_q <= (byte_count == 16'h0000) ? whole_len : len; // R2
                            st_q <= `CCM_ST_WR;
                        end else begin
                            case (manage_mode)
                                `CCM_MODE_INC, `CCM_MODE_DEC: begin
                                    op_q <= (manage_mode == `CCM_MODE_INC) ?
                                            `CCM_OP_INC : `CCM_OP_DEC; // R7
                                    rd_n_q <= `CCM_CNT_BYTES; // R6
                                    wr_n_q <= `CCM_CNT_BYTES;
                                    st_q <= `CCM_ST_RD;
                                end
                                `CCM_MODE_GEN: begin
                                    op_q <= `CCM_OP_GEN;
                                    rd_n_q <= len - `CCM_CODE_BYTES; // R11
                                    wr_n_q <= `CCM_CODE_BYTES;
                                    st_q <= (len == `CCM_CODE_BYTES) ? `CCM_ST_WR : `CCM_ST_RD;
                                end
                                default: begin
                                    op_q <= `CCM_OP_VER;
                                    rd_n_q <= len; // R14
                                    wr_n_q <= 17'h00000;
                                    st_q <= `CCM_ST_RD;
                                end
                            endcase
                            // an area too short to hold the code is an error end
                            if (manage_mode[1] && (len < `CCM_CODE_BYTES)) begin
                                comm_err_q <= 1'b1;
                                st_q <= `CCM_ST_FIN;
                            end
                        end
                    end
                end
                `CCM_ST_RD: begin
                    if (!mem_req_q) begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= addr_q;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        if (mem_err) begin
                            comm_err_q <= 1'b1; // R4
                            st_q <= `CCM_ST_FIN;
                        end else begin
                            cnt_q <= {cnt_q[15:0], mem_rdata}; // R6
                            crc_q <= crc_d; // R13
                            addr_q <= addr_q + 16'h0001;
                            rd_n_q <= rd_n_q - 17'h00001;
                            if (rd_n_q == 17'h00001) begin
                                st_q <= `CCM_ST_CALC;
                            end
                        end
                    end
                end
                `CCM_ST_CALC: begin
                    case (op_q)
                        `CCM_OP_INC: begin
                            // saturate rather than wrap past three bytes
                            cnt_q <= sum[24] ? `CCM_CNT_MAX : sum[23:0]; // R9
                            if (sum > `CCM_CNT_LIMIT) begin
                                check_warn_q <= 1'b1; // R9
                            end
                        end
                        `CCM_OP_DEC: begin
                            if ({8'h00, step_q} >= cnt_q) begin
                                cnt_q <= 24'h000000; // R10
                                check_warn_q <= 1'b1; // R10
                            end else begin
                                cnt_q <= cnt_q - {8'h00, step_q}; // R10
                            end
                        end
                        `CCM_OP_VER: begin
                            if (crc_q != 16'h0000) begin
                                check_warn_q <= 1'b1; // R13
                            end
                        end
                        default: begin
                            check_warn_q <= check_warn_q;
                        end
                    endcase
                    if ((op_q == `CCM_OP_INC) || (op_q == `CCM_OP_DEC)) begin
                        addr_q <= base_q; // R6
                    end
                    idx_q <= 2'h0;
                    st_q <= (wr_n_q == 17'h00000) ? `CCM_ST_FIN : `CCM_ST_WR;
                end
                `CCM_ST_WR: begin
                    if (!mem_req_q) begin
                        if (skip) begin
                            addr_q <= addr_q + 16'h0001; // R3
                            wr_n_q <= wr_n_q - 17'h00001;
                            if (wr_n_q == 17'h00001) begin
                                st_q <= `CCM_ST_FIN;
                            end
                        end else begin
                            mem_req_q <= 1'b1; // R1
                            mem_we_q <= 1'b1;
                            mem_addr_q <= addr_q;
                            mem_wdata_q <= wbyte;
                        end
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        if (mem_err) begin
                            comm_err_q <= 1'b1; // R4
                            st_q <= `CCM_ST_FIN;
                        end else begin
                            addr_q <= addr_q + 16'h0001;
                            idx_q <= idx_q + 2'h1;
                            wr_n_q <= wr_n_q - 17'h00001;
                            if (wr_n_q == 17'h00001) begin
                                st_q <= `CCM_ST_FIN;
                            end
                        end
                    end
                end
                `CCM_ST_FIN: begin
                    done_q <= 1'b1; // R4
                    ready_q <= 1'b1;
                    st_q <= `CCM_ST_IDLE;
                end
                default: begin
                    st_q <= `CCM_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // completion handlers
    // ----------------------------------------
    // a read and a write ending together start only the read handler
    always @(posedge mclk) begin
        if (!rst_n) begin
            handler_start_q <= 1'b0;
            handler_entry_q <= 8'h00;
        end else begin
            handler_start_q <= 1'b0;
            if (refresh_irq_sel && carrier_read_done) begin
                handler_start_q <= 1'b1; // R16
                handler_entry_q <= `CCM_HANDLER_READ; // R16
            end else if (refresh_irq_sel && carrier_write_done) begin
                handler_start_q <= 1'b1; // R16
                handler_entry_q <= `CCM_HANDLER_WRITE; // R16
            end
        end
    end
endmodule // ccm_unit
`default_nettype wire

// ### src/ccm_defs.vh
// constants of the carrier clear and manage unit
`ifndef CCM_DEFS_VH
`define CCM_DEFS_VH
// ----------------------------------------
// sequencer states
// ----------------------------------------
`define CCM_ST_IDLE 3'h0
`define CCM_ST_RD 3'h1
`define CCM_ST_CALC 3'h2
`define CCM_ST_WR 3'h3
`define CCM_ST_FIN 3'h4
// ----------------------------------------
// internal operations
// ----------------------------------------
`define CCM_OP_CLR 3'h0
`define CCM_OP_INC 3'h1
`define CCM_OP_DEC 3'h2
`define CCM_OP_GEN 3'h3
`define CCM_OP_VER 3'h4
// ----------------------------------------
// manage mode codes on manage_mode
// ----------------------------------------
`define CCM_MODE_INC 2'h0
`define CCM_MODE_DEC 2'h1
`define CCM_MODE_GEN 2'h2
`define CCM_MODE_VER 2'h3
// ----------------------------------------
// counts, limits and codes
// ----------------------------------------
`define CCM_CNT_BYTES 17'h00003
`define CCM_CODE_BYTES 17'h00002
`define CCM_CNT_LIMIT 25'h00186a0
`define CCM_CNT_MAX 24'hffffff
`define CCM_CRC_PRESET 16'hffff
`define CCM_CRC_POLY 16'h1021
`define CCM_HANDLER_READ 8'h04
`define CCM_HANDLER_WRITE 8'h05
`endif

// ### src/ccm_crc_byte.v
// one byte step of the check code, msb first
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.vh"
module ccm_crc_byte (
    // running value and new byte
    input wire [15:0] crc_in,
    input wire [7:0] data_in,
    // updated value
    output reg [15:0] crc_out
);
    integer i;
    reg fb;
    always @* begin
        crc_out = crc_in;
        fb = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = crc_out[15] ^ data_in[i];
            crc_out = {crc_out[14:0], 1'b0} ^ (fb ? `CCM_CRC_POLY : 16'h0000); // R12 R18
        end
    end
endmodule // ccm_crc_byte
`default_nettype wire

// ### tb/ccm_assertions.sv
// port checker of the carrier clear and manage unit
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.vh"
module ccm_assertions (
    // clock, reset, commands
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic carrier_clear_cmd,
    input wire logic carrier_manage_cmd,
    input wire logic carrier_present,
    // status
    input wire logic ready_q,
    input wire logic done_q,
    input wire logic comm_err_q,
    input wire logic missing_err_q,
    input wire logic check_warn_q,
    // memory port
    input wire logic mem_req_q,
    input wire logic mem_we_q,
    input wire logic [15:0] mem_addr_q,
    input wire logic mem_ack,
    // handlers
    input wire logic refresh_irq_sel,
    input wire logic carrier_read_done,
    input wire logic carrier_write_done,
    input wire logic handler_start_q,
    input wire logic [7:0] handler_entry_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_take_drops_ready: assert property (
        ready_q && (carrier_clear_cmd || carrier_manage_cmd) |=> !ready_q)
        else $error("ready stayed high after a take");
    a_done_with_ready: assert property ($rose(done_q) |-> ready_q)
        else $error("done rose while busy");
    a_err_ends_done: assert property (comm_err_q && ready_q |-> done_q)
        else $error("error flag without done");
    a_idle_no_req: assert property (ready_q |-> !mem_req_q)
        else $error("memory request while idle");
    a_req_held: assert property (
        mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
        else $error("request changed before ack");
    a_req_release: assert property (mem_req_q && mem_ack |=> !mem_req_q)
        else $error("request held after ack");
    a_missing_end: assert property (
        ready_q && carrier_clear_cmd && !carrier_present && !$past(carrier_present)
        && !$past(carrier_present, 2)
        |=> !mem_req_q ##1 (done_q && missing_err_q && !mem_req_q))
        else $error("missing carrier not reported");
    a_warn_cleared: assert property (
        ready_q && carrier_manage_cmd && !carrier_clear_cmd |=> !check_warn_q && !done_q)
        else $error("warning kept over a new manage");
    a_handler_read: assert property (
        refresh_irq_sel && carrier_read_done
        |-> ##[1:2] (handler_start_q && handler_entry_q == `CCM_HANDLER_READ))
        else $error("read handler not started");
    a_handler_write: assert property (
        refresh_irq_sel && carrier_write_done && !carrier_read_done
        |-> ##[1:2] (handler_start_q && handler_entry_q == `CCM_HANDLER_WRITE))
        else $error("write handler not started");
endmodule // ccm_assertions
bind ccm_unit ccm_assertions i_chk (.mclk, .rst_n, .carrier_clear_cmd, .carrier_manage_cmd,
    .carrier_present, .ready_q, .done_q, .comm_err_q, .missing_err_q, .check_warn_q, .mem_req_q,
    .mem_we_q, .mem_addr_q, .mem_ack, .refresh_irq_sel, .carrier_read_done, .carrier_write_done,
    .handler_start_q, .handler_entry_q);
`default_nettype wire

// ### tb/ccm_mem_model.sv
// carrier memory behind the read/write head
`timescale 1ns/100ps
`default_nettype none
module ccm_mem_model (
    // clock, reset, pacing
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic err_inj,
    // head memory port
    input wire logic mem_req_q,
    input wire logic mem_we_q,
    input wire logic [15:0] mem_addr_q,
    input wire logic [7:0] mem_wdata_q,
    output logic mem_ack = 1'h0,
    output logic mem_err = 1'h0,
    output logic [7:0] mem_rdata = 8'h5a
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_q = 2'h0;
    // read data flips when idle so a stale byte never passes
    always @(posedge mclk) begin
        mem_ack <= 1'h0;
        mem_err <= 1'h0;
        mem_rdata <= ~mem_rdata;
        if (!rst_n || !mem_req_q || mem_ack) begin
            wait_q <= 2'h0;
        end else if (wait_q != {slow, slow}) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            mem_ack <= 1'h1;
            mem_err <= err_inj;
            if (mem_we_q) mem[mem_addr_q] <= mem_wdata_q;
            else mem_rdata <= mem[mem_addr_q];
        end
    end
endmodule // ccm_mem_model
`default_nettype wire

// ### tb/ccm_unit_tb_top.sv
// self-checking bench of the carrier clear and manage unit
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defs.vh"
module carrier_clear_manage_unit_tb_top;
    typedef struct packed {
        logic [1:0] mode;
        logic [23:0] pre;
        logic [15:0] step;
        logic [23:0] cnt;
        logic warn;
    } ccm_row_t;
    logic mclk = 1'h0, rst_n = 1'h0, slow = 1'h0, err_inj = 1'h0, carrier_present = 1'h1;
    logic carrier_clear_cmd = 1'h0, carrier_manage_cmd = 1'h0, refresh_irq_sel = 1'h0;
    logic carrier_read_done = 1'h0, carrier_write_done = 1'h0;
    logic [15:0] first_addr = 16'h0000, byte_count = 16'h0000, step_count = 16'h0000;
    logic [15:0] last_addr = 16'h001f, prod_addr = 16'h0010, mem_addr_q;
    logic [7:0] fill_byte = 8'h00, mem_wdata_q, mem_rdata, handler_entry_q;
    logic [1:0] manage_mode = 2'h0;
    logic ready_q, done_q, comm_err_q, missing_err_q, check_warn_q, mem_req_q, mem_we_q;
    logic mem_ack, mem_err, handler_start_q;
    int bad_count = 0, tests_run = 0, cyc = 0;
    ccm_row_t rows [5] = '{
        '{`CCM_MODE_INC, 24'h01869b, 16'h0005, 24'h0186a0, 1'h0},
        '{`CCM_MODE_INC, 24'h0186a0, 16'h0001, 24'h0186a1, 1'h1},
        '{`CCM_MODE_DEC, 24'h000005, 16'h0003, 24'h000002, 1'h0},
        '{`CCM_MODE_DEC, 24'h000003, 16'h0003, 24'h000000, 1'h1},
        '{`CCM_MODE_DEC, 24'h000002, 16'h0005, 24'h000000, 1'h1}};
    ccm_unit i_dut (.mclk, .rst_n, .carrier_clear_cmd, .carrier_manage_cmd, .first_addr,
        .byte_count, .fill_byte, .manage_mode, .step_count, .last_addr, .prod_addr,
        .carrier_present, .ready_q, .done_q, .comm_err_q, .missing_err_q, .check_warn_q,
        .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_err, .mem_rdata,
        .refresh_irq_sel, .carrier_read_done, .carrier_write_done, .handler_start_q,
        .handler_entry_q);
    ccm_mem_model i_mem (.mclk, .rst_n, .slow, .err_inj, .mem_req_q, .mem_we_q, .mem_addr_q,
        .mem_wdata_q, .mem_ack, .mem_err, .mem_rdata);
    always #50 mclk = ~mclk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic clr, input logic [1:0] mode, input logic [15:0] addr, cnt, step,
                       input logic [7:0] fill, input logic [1:0] st);
        int n;
        n = 0;
        @(posedge mclk);
        carrier_clear_cmd <= clr;
        carrier_manage_cmd <= ~clr;
        {manage_mode, first_addr, byte_count, step_count, fill_byte} <= {mode, addr, cnt, step, fill};
        @(posedge mclk);
        carrier_clear_cmd <= 1'h0;
        carrier_manage_cmd <= 1'h0;
        #1;
        while (n < 2000 && !(done_q === 1'h1 && ready_q === 1'h1)) begin
            @(posedge mclk);
            #1 n++;
        end
        chk({done_q, comm_err_q, missing_err_q}, {1'h1, st}, "end flags");
    endtask
    task automatic hand(input logic [2:0] in, input logic [8:0] exp);
        logic [8:0] got;
        got = 9'h000;
        @(posedge mclk);
        {refresh_irq_sel, carrier_read_done, carrier_write_done} <= in;
        @(posedge mclk);
        {carrier_read_done, carrier_write_done} <= 2'h0;
        repeat (3) begin
            #1 if (handler_start_q === 1'h1) got = {1'h1, handler_entry_q};
            @(posedge mclk);
        end
        chk(got, exp, "handler");
    endtask
    // ----------------------------------------
    // cycle ceiling and main sequence
    // ----------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        logic [15:0] crc;
        crc = 16'hffff;
        @(posedge mclk);
        #1 chk({ready_q, done_q, comm_err_q, missing_err_q, check_warn_q, mem_req_q,
            handler_start_q, handler_entry_q}, 24'h004000, "reset values");
        @(posedge mclk);
        rst_n <= 1'h1;
        // presence synchroniser needs two edges before the first take
        repeat (2) @(posedge mclk);
        foreach (rows[i]) begin
            slow = i[0];
            {i_mem.mem[16'h0041], i_mem.mem[16'h0042], i_mem.mem[16'h0043]} = rows[i].pre;
            run(1'h0, rows[i].mode, 16'h0041, 16'h0003, rows[i].step, 8'h00, 2'h0);
            chk({i_mem.mem[16'h0041], i_mem.mem[16'h0042], i_mem.mem[16'h0043]},
                rows[i].cnt, "count");
            chk(check_warn_q, rows[i].warn, "warn");
        end
        $display("counter rows done");
        // host fills data only, code bytes left to the unit
        for (int k = 0; k < 4; k++) begin
            i_mem.mem[16'h0050 + 16'(k)] = 8'h31 + 8'(k);
            crc = crc ^ {8'h31 + 8'(k), 8'h00};
            repeat (8) crc = crc[15] ? {crc[14:0], 1'h0} ^ 16'h1021 : {crc[14:0], 1'h0};
        end
        run(1'h0, `CCM_MODE_GEN, 16'h0050, 16'h0006, 16'h0000, 8'h00, 2'h0);
        chk({i_mem.mem[16'h0054], i_mem.mem[16'h0055]}, crc, "code");
        slow = 1'h0;
        run(1'h0, `CCM_MODE_VER, 16'h0050, 16'h0006, 16'h0000, 8'h00, 2'h0);
        chk(check_warn_q, 1'h0, "good code");
        for (int k = 0; k < 2; k++) begin
            i_mem.mem[16'h0053 + 16'(2 * k)] ^= 8'h01;
            run(1'h0, `CCM_MODE_VER, 16'h0050, 16'h0006, 16'h0000, 8'h00, 2'h0);
            chk(check_warn_q, 1'h1, "bad code");
            i_mem.mem[16'h0053 + 16'(2 * k)] ^= 8'h01;
        end
        $display("check code done");
        for (int k = 0; k < 32; k++) i_mem.mem[k] = 8'hff;
        i_mem.mem[16'h0100] = 8'h77;
        i_mem.mem[16'h0101] = 8'h77;
        run(1'h1, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h00, 2'h0);
        for (int k = 0; k < 32; k++) begin
            chk(i_mem.mem[k], (k == 16 || k == 17) ? 8'hff : 8'h00, "whole");
        end
        run(1'h1, 2'h0, 16'h0100, 16'h0001, 16'h0000, 8'ha5, 2'h0);
        chk({i_mem.mem[16'h0100], i_mem.mem[16'h0101]}, 16'ha577, "range");
        $display("clear done");
        err_inj = 1'h1;
        run(1'h1, 2'h0, 16'h0200, 16'h0001, 16'h0000, 8'h00, 2'h2);
        run(1'h0, `CCM_MODE_VER, 16'h0050, 16'h0006, 16'h0000, 8'h00, 2'h2);
        err_inj = 1'h0;
        // an area too short for the code ends with an error
        run(1'h0, `CCM_MODE_GEN, 16'h0060, 16'h0001, 16'h0000, 8'h00, 2'h2);
        carrier_present <= 1'h0;
        repeat (3) @(posedge mclk);
        run(1'h1, 2'h0, 16'h0100, 16'h0001, 16'h0000, 8'h3c, 2'h3);
        chk(i_mem.mem[16'h0100], 8'ha5, "untouched");
        carrier_present <= 1'h1;
        repeat (3) @(posedge mclk);
        $display("error ends done");
        hand(3'h6, 9'h104);
        hand(3'h5, 9'h105);
        hand(3'h7, 9'h104);
        hand(3'h2, 9'h000);
        $display("handlers done");
        test_done();
    end
endmodule // carrier_clear_manage_unit_tb_top
`default_nettype wire
